// ### dv/jpo_amp_model.sv
// jpo_amp_model.sv: amplifier model counting reverse steps
// assumes: sel_i high selects separate forward/reverse pulse lines
`timescale 1ns/1ns
module jpo_amp_model (
   input wire clk_i,
   input wire pulse_i,
   input wire dir_i,
   input wire sel_i,
   output int steps_o
);
   logic p_q = 1'b0;
   wire tr = sel_i ? dir_i : pulse_i;
   initial steps_o = 0;
   // one step per rising edge, sign from method and direction
   always @(posedge clk_i) begin
      p_q <= tr;
      if (tr && !p_q) steps_o <= steps_o + ((sel_i || !dir_i) ? -1 : 1);
   end
endmodule

// ### dv/jpo_top_sva.sv
// jpo_top_sva.sv: port checker for the reverse jog pulse block
// assumes: bound to jpo_top, one clock, synchronous active high reset
`timescale 1ns/1ns
module jpo_top_sva (
   input wire clk_i,
   input wire rst_i,
   input wire rev_limit_in_i,
   input wire jog_fwd_in_i,
   input wire jog_rev_in_i,
   input wire pulse_out_o,
   input wire dir_out_o,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   input wire s_axi_rready
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // only one line may carry the reverse train
   a_one_line_only: assert property (!(pulse_out_o && dir_out_o)) else $error("both lines high");
   // releasing jog, limit or holding forward jog quiets both lines
   a_stop_release: assert property (!jog_rev_in_i [*8] |=> !pulse_out_o && !dir_out_o)
      else $error("lines active after release");
   a_stop_limit: assert property (!rev_limit_in_i [*8] |=> !pulse_out_o && !dir_out_o)
      else $error("lines active at limit");
   a_fwd_blocks: assert property (jog_fwd_in_i [*8] |=> !pulse_out_o && !dir_out_o)
      else $error("reverse run with forward jog");
   a_dir_settled: assert property ($rose(pulse_out_o) |-> $stable(dir_out_o)) else $error("dir moved");
   // write answers one cycle after both items sit held, read one cycle after acceptance
   a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
      else $error("no write response");
   a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
   a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read data");
   a_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid stuck");
endmodule
bind jpo_top jpo_top_sva jpo_top_sva_i (.*);

// ### dv/tb_jpo_top.sv
// tb_jpo_top.sv: self-checking bench for the reverse jog block
// assumes: design, checker and amplifier model compiled before
`timescale 1ns/1ns
module tb_jpo_top;
   // limits closed and jogs open at rest
   logic clk_i = 0, rst_i = 1, fl = 1, rl = 1, jf = 0, jr = 0, m = 0;
   logic [7:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rd, p;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [1:0] rs;
   wire awready, wready, bvalid, arready, rvalid, pls, dir, irq;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   int miscompares = 0, compares = 0, st;
   always #4 clk_i = ~clk_i;
   jpo_top jpo_top_i (.clk_i(clk_i), .rst_i(rst_i), .fwd_limit_in_i(fl), .rev_limit_in_i(rl), .jog_fwd_in_i(jf),
      .jog_rev_in_i(jr), .pulse_out_o(pls), .dir_out_o(dir), .irq_o(irq), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   jpo_amp_model jpo_amp_model_i (.clk_i(clk_i), .pulse_i(pls), .dir_i(dir), .sel_i(m), .steps_o(st));
   task report_and_stop;
      $display("mismatches %0d compares %0d", miscompares, compares);
      if (miscompares == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // axi4-lite write, address and data offered together
   task wr(input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clk_i);
      awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
      for (i = 0; i < 50; i++) begin
         @(posedge clk_i);
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
         if (bvalid) break;
      end
      bready <= 0; rs = bresp;
      if (i == 50) begin miscompares++; report_and_stop; end
   endtask
   // axi4-lite read
   task rdr(input logic [7:0] a);
      int i;
      @(posedge clk_i);
      araddr <= a; arvalid <= 1; rready <= 1;
      for (i = 0; i < 50; i++) begin
         @(posedge clk_i);
         if (arready) arvalid <= 0;
         if (rvalid) break;
      end
      rready <= 0; rd = rdata; rs = rresp;
      if (i == 50) begin miscompares++; report_and_stop; end
   endtask
   // reset values and an unmapped place
   task s_reset;
      rdr(8'h18); chk("half_per", rd, 32'h0000_0004);
      rdr(8'h04); chk("status", rd, 32'h0000_0000);
      rdr(8'h08); chk("pos_lo", rd, 32'h0000_0000);
      rdr(8'h1C); chk("unmapped_resp", rs, 2'b10); chk("unmapped_data", rd, 32'h0000_0000);
   endtask
   // forward jog held refuses reverse run
   task s_fwd;
      int s0;
      @(posedge clk_i); jf <= 1; cyc(10); jr <= 1; s0 = st; cyc(60);
      rdr(8'h04); chk("status_fwd", rd, 32'h0000_0000);
      chk("no_steps", st, s0);
      @(posedge clk_i); jr <= 0; jf <= 0; cyc(10);
   endtask
   // reverse run in one method, release, position and stop event
   task s_run(input logic meth);
      int s0, d;
      @(posedge clk_i); m <= meth;
      wr(8'h00, {30'h0, 1'b1, meth}); wr(8'h14, 32'h0000_0003); s0 = st;
      @(posedge clk_i); jr <= 1; cyc(100);
      rdr(8'h04); chk("busy", rd, 32'h0000_0001);
      @(posedge clk_i); jr <= 0; cyc(20);
      rdr(8'h08); p[15:0] = rd[15:0]; rdr(8'h0C); p[31:16] = rd[15:0];
      d = $signed(p) - (st - s0);
      chk("moved", (st - s0) < 0, 1);
      chk("pos", d == 0 || d == 1, 1);
      cyc(20); rdr(8'h08); chk("pos_hold", rd[15:0], p[15:0]);
      chk("irq_done", irq, 1); rdr(8'h10); chk("irq_stat", rd, 32'h0000_0002);
      wr(8'h10, 32'h0000_0002); chk("irq_clear", irq, 0);
   endtask
   // reverse limit opens mid run
   task s_limit;
      wr(8'h00, 32'h0000_0002); wr(8'h14, 32'h0000_0000); m <= 0;
      @(posedge clk_i); jr <= 1; cyc(60); rl <= 0; cyc(20); jr <= 0; cyc(10);
      rdr(8'h04); chk("status_lim", rd, 32'h0000_000A);
      rdr(8'h10); chk("irq_stat_lim", rd, 32'h0000_0003);
      chk("irq_masked", irq, 0);
      wr(8'h14, 32'h0000_0001); chk("irq_unmasked", irq, 1);
      wr(8'h10, 32'h0000_0003); chk("irq_cleared", irq, 0);
      @(posedge clk_i); rl <= 1; cyc(10);
   endtask
   initial begin
      cyc(10);
      rst_i <= 0;
      cyc(2);
      s_reset;
      s_fwd;
      s_run(0);
      s_run(1);
      s_limit;
      report_and_stop;
   end
endmodule

// ### rtl/jpo_defines.vh
// jpo_defines.vh: constants and register map of the reverse jog pulse output block
// assumes: included by the rtl files of the block; definitions only
// Notes on behaviour
// - reverse jog alone with limits on runs reverse
// - reverse: pulse toggles, direction off, forward line off
// - position counter decrements once per pulse
// - on stop, pulse lines rest off
// - on stop, position counter holds its value
// - reverse limit off stops motion like normal stop
// - reverse limit stop sets abnormal end flag
// - position is 32 bits in two 16-bit halves
// - reverse limit flag follows open limit contact
// - busy flag high while motion is active
`ifndef JPO_DEFINES_VH
`define JPO_DEFINES_VH

// register byte offsets
`define JPO_REG_CTRL 8'h00
`define JPO_REG_STATUS 8'h04
`define JPO_REG_POS_LO 8'h08
`define JPO_REG_POS_HI 8'h0C
`define JPO_REG_IRQ_STAT 8'h10
`define JPO_REG_IRQ_MASK 8'h14
`define JPO_REG_HALF_PER 8'h18

// ctrl fields
`define JPO_CTRL_METHOD 0
`define JPO_CTRL_POS_CLR 1

// status fields
`define JPO_ST_BUSY 0
`define JPO_ST_REV_LIM 1
`define JPO_ST_FWD_LIM 2
`define JPO_ST_ABN 3

// irq bits
`define JPO_IRQ_ABN 0
`define JPO_IRQ_DONE 1
`define JPO_IRQ_W 2

// reset and timing values
`define JPO_HALF_PER_RST 16'h0004
`define JPO_DIR_SETUP 16'h0002
`define JPO_RESP_OKAY 2'b00
`define JPO_RESP_SLVERR 2'b10

`endif

// ### rtl/jpo_sync3.v
// jpo_sync3.v: three flip-flop input synchroniser with agreement filter
// assumes: in_i is asynchronous to clk_i; reset is synchronous active high
`timescale 1ns/1ns
module jpo_sync3 #(
   parameter RST_VAL = 1'b0
) (
   input wire clk_i,
   input wire rst_i,
   input wire in_i,
   output wire out_o
);
   reg s1_q;
   reg s2_q;
   reg s3_q;
   reg out_q;

   // chain; only s2 reads s1, output changes when s2 and s3 agree
   always @(posedge clk_i) begin
      if (rst_i) begin
         s1_q <= RST_VAL;
         s2_q <= RST_VAL;
         s3_q <= RST_VAL;
         out_q <= RST_VAL;
      end else begin
         s1_q <= in_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            out_q <= s3_q;
         end
      end
   end

   assign out_o = out_q;
endmodule

// ### rtl/jpo_top.v
// jpo_top.v: reverse jog pulse train generator with axi4-lite registers
// assumes: limit and jog inputs come from switches on an unrelated clock;
// outputs drive an amplifier; one 125 MHz clock, synchronous reset
//
// Design decisions made here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "jpo_defines.vh"
module jpo_top #(
   parameter AW = 8
) (
   input wire clk_i,
   input wire rst_i,
   input wire fwd_limit_in_i,
   input wire rev_limit_in_i,
   input wire jog_fwd_in_i,
   input wire jog_rev_in_i,
   output wire pulse_out_o,
   output wire dir_out_o,
   output wire irq_o,
   input wire [AW-1:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output wire [1:0] s_axi_bresp,
   output wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [AW-1:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output wire [31:0] s_axi_rdata,
   output wire [1:0] s_axi_rresp,
   output wire s_axi_rvalid,
   input wire s_axi_rready
);
   localparam ST_IDLE = 3'b001;
   localparam ST_SETUP = 3'b010;
   localparam ST_RUN = 3'b100;

   wire fwd_lim_s;
   wire rev_lim_s;
   wire jog_fwd_s;
   wire jog_rev_s;
   wire [3:0] raw;
   wire [3:0] syn;

   reg [2:0] state_q;
   reg [15:0] cnt_q;
   reg pulse_q;
   reg dir_q;
   reg [31:0] pos_q;
   reg abn_q;
   reg method_q;
   reg [15:0] half_per_q;
   reg [`JPO_IRQ_W-1:0] irq_stat_q;
   reg [`JPO_IRQ_W-1:0] irq_mask_q;

   reg [AW-1:0] awaddr_q;
   reg aw_full_q;
   reg [31:0] wdata_q;
   reg [3:0] wstrb_q;
   reg w_full_q;
   reg bvalid_q;
   reg [1:0] bresp_q;
   reg rvalid_q;
   reg [31:0] rdata_q;
   reg [1:0] rresp_q;

   // limits rest closed (high) so reset them to on; jogs rest open
   assign raw = {fwd_limit_in_i, rev_limit_in_i, jog_fwd_in_i, jog_rev_in_i};
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
         jpo_sync3 #(.RST_VAL(gi >= 2 ? 1'b1 : 1'b0)) u_sync (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .in_i(raw[gi]),
            .out_o(syn[gi])
         );
      end
   endgenerate
   assign jog_rev_s = syn[0];
   assign jog_fwd_s = syn[1];
   assign rev_lim_s = syn[2]; // low means contact opened
   assign fwd_lim_s = syn[3];

   // start and keep-running condition for reverse jog
   wire run_ok = jog_rev_s & ~jog_fwd_s & fwd_lim_s & rev_lim_s;
   wire lim_hit = ~rev_lim_s;
   wire busy = (state_q != ST_IDLE);
   wire pulse_fall = (state_q == ST_RUN) && (cnt_q == 16'h0000) && pulse_q;
   wire stop_now = (state_q != ST_IDLE) && ~run_ok;
   wire ev_abn = stop_now && lim_hit;
   wire ev_done = stop_now;

   // motion state machine and pulse generator
   always @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= ST_IDLE;
         cnt_q <= 16'h0000;
         pulse_q <= 1'b0;
         dir_q <= 1'b0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               pulse_q <= 1'b0;
               if (run_ok) begin
                  dir_q <= 1'b0; // reverse sets direction off first
                  cnt_q <= `JPO_DIR_SETUP;
                  state_q <= ST_SETUP;
               end
            end
            ST_SETUP: begin
               if (~run_ok) begin
                  state_q <= ST_IDLE;
               end else if (cnt_q == 16'h0000) begin
                  cnt_q <= half_per_q;
                  state_q <= ST_RUN;
               end else begin
                  cnt_q <= cnt_q - 16'h0001;
               end
            end
            ST_RUN: begin
               if (~run_ok) begin
                  pulse_q <= 1'b0; // line rests off
                  state_q <= ST_IDLE;
               end else if (cnt_q == 16'h0000) begin
                  pulse_q <= ~pulse_q;
                  cnt_q <= half_per_q;
               end else begin
                  cnt_q <= cnt_q - 16'h0001;
               end
            end
            default: begin
               state_q <= ST_IDLE;
               pulse_q <= 1'b0;
            end
         endcase
      end
   end

   // pulse+direction uses both pins; fwd/rev method: pin0 forward (off), pin1 reverse pulses
   assign pulse_out_o = method_q ? 1'b0 : pulse_q;
   assign dir_out_o = method_q ? pulse_q : dir_q;

   // 32-bit position, counts down on each completed pulse
   always @(posedge clk_i) begin
      if (rst_i) begin
         pos_q <= 32'h0000_0000;
      end else if (pulse_fall && run_ok) begin
         pos_q <= pos_q - 32'h0000_0001;
      end else if (aw_full_q && w_full_q && !bvalid_q && awaddr_q == `JPO_REG_CTRL &&
                   wstrb_q[0] && wdata_q[`JPO_CTRL_POS_CLR]) begin
         pos_q <= 32'h0000_0000;
      end
   end

   // abnormal end flag: set by reverse limit stop, cleared by next start
   always @(posedge clk_i) begin
      if (rst_i) begin
         abn_q <= 1'b0;
      end else if (ev_abn) begin
         abn_q <= 1'b1;
      end else if (state_q == ST_IDLE && run_ok) begin
         abn_q <= 1'b0;
      end
   end

   // axi write: address and data taken in either order, response after both
   wire wr_go = aw_full_q && w_full_q && !bvalid_q;
   assign s_axi_awready = !aw_full_q && !bvalid_q;
   assign s_axi_wready = !w_full_q && !bvalid_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;

   function is_mapped;
      input [AW-1:0] a;
      begin
         is_mapped = (a == `JPO_REG_CTRL) || (a == `JPO_REG_STATUS) || (a == `JPO_REG_POS_LO) ||
                     (a == `JPO_REG_POS_HI) || (a == `JPO_REG_IRQ_STAT) ||
                     (a == `JPO_REG_IRQ_MASK) || (a == `JPO_REG_HALF_PER);
      end
   endfunction

   wire [`JPO_IRQ_W-1:0] ev_vec = {ev_done, ev_abn};
   wire [`JPO_IRQ_W-1:0] w1c = (wr_go && awaddr_q == `JPO_REG_IRQ_STAT && wstrb_q[0]) ?
                               wdata_q[`JPO_IRQ_W-1:0] : {`JPO_IRQ_W{1'b0}};

   always @(posedge clk_i) begin
      if (rst_i) begin
         awaddr_q <= {AW{1'b0}};
         aw_full_q <= 1'b0;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         w_full_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= `JPO_RESP_OKAY;
         method_q <= 1'b0;
         half_per_q <= `JPO_HALF_PER_RST;
         irq_mask_q <= {`JPO_IRQ_W{1'b0}};
         irq_stat_q <= {`JPO_IRQ_W{1'b0}};
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awaddr_q <= s_axi_awaddr;
            aw_full_q <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
            w_full_q <= 1'b1;
         end
         // sticky status: set wins over write-one-clear
         irq_stat_q <= (irq_stat_q & ~w1c) | ev_vec;
         if (wr_go) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= is_mapped(awaddr_q) ? `JPO_RESP_OKAY : `JPO_RESP_SLVERR;
            if (awaddr_q == `JPO_REG_CTRL && wstrb_q[0]) begin
               method_q <= wdata_q[`JPO_CTRL_METHOD];
            end
            if (awaddr_q == `JPO_REG_IRQ_MASK && wstrb_q[0]) begin
               irq_mask_q <= wdata_q[`JPO_IRQ_W-1:0];
            end
            if (awaddr_q == `JPO_REG_HALF_PER) begin
               if (wstrb_q[0]) begin
                  half_per_q[7:0] <= wdata_q[7:0];
               end
               if (wstrb_q[1]) begin
                  half_per_q[15:8] <= wdata_q[15:8];
               end
            end
         end else if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // axi read: one-cycle registered answer
   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   always @(posedge clk_i) begin
      if (rst_i) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= `JPO_RESP_OKAY;
      end else if (s_axi_arvalid && !rvalid_q) begin
         rvalid_q <= 1'b1;
         rresp_q <= is_mapped(s_axi_araddr) ? `JPO_RESP_OKAY : `JPO_RESP_SLVERR;
         case (s_axi_araddr)
            `JPO_REG_CTRL: rdata_q <= {31'h0000_0000, method_q};
            `JPO_REG_STATUS: rdata_q <= {28'h000_0000, abn_q, ~fwd_lim_s, ~rev_lim_s, busy};
            `JPO_REG_POS_LO: rdata_q <= {16'h0000, pos_q[15:0]};
            `JPO_REG_POS_HI: rdata_q <= {16'h0000, pos_q[31:16]};
            `JPO_REG_IRQ_STAT: rdata_q <= {30'h0000_0000, irq_stat_q};
            `JPO_REG_IRQ_MASK: rdata_q <= {30'h0000_0000, irq_mask_q};
            `JPO_REG_HALF_PER: rdata_q <= {16'h0000, half_per_q};
            default: rdata_q <= 32'h0000_0000;
         endcase
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   assign irq_o = |(irq_stat_q & irq_mask_q);
endmodule
